// [logic/smi_source_status_flags.v]
`include "smi_flags_defines.vh"

module smi_source_status_flags #(
  parameter CENTURY_CLEAR_DELAY = `CENTURY_CLEAR_RTC_CLKS
) (
  // Clock, enable, resets
  input wire I_MCLK,
  input wire I_RESET_N,
  input wire I_CE,
  input wire I_RTC_WELL_RESET_N,
  // Register port
  input wire i_REG_WR,
  input wire i_REG_RD,
  input wire [7:0] i_REG_ADDR,
  input wire [15:0] i_REG_WDATA,
  output reg [15:0] O_REG_RDATA,
  // Firmware protection
  input wire i_FIRMWARE_WRITE_PERMIT,
  input wire i_FIRMWARE_LOCK_DOWN,
  input wire i_FW_WRITE_CYCLE,
  input wire i_FW_WRITE_LOWER_ALIAS,
  // Event sources
  input wire i_RTC_TICK,
  input wire i_YEAR_WR,
  input wire [7:0] i_YEAR_INDEX,
  input wire [7:0] i_YEAR_OLD,
  input wire [7:0] i_YEAR_NEW,
  input wire i_WATCHDOG_ZERO,
  input wire i_OUTBOUND_MESSAGE_WR,
  input wire i_INBOUND_MESSAGE_WR,
  input wire i_NMI_EVENT,
  input wire i_NMI_REROUTE_ENABLE,
  input wire i_NMI_STATUS_CLEAR,
  // Secondary status event sources
  input wire i_INTRUDER_EVENT,
  input wire i_SECOND_TIMEOUT_EVENT,
  input wire i_BOOT_EVENT,
  input wire i_SMLINK_SLAVE_EVENT,
  // Outputs
  output reg O_MGMT_INTERRUPT_N,
  output reg O_WAKE_EVENT,
  output reg O_NMI
);

  // ==================================================
  // Reset release and pin synchronisers
  wire rst_n;
  wire rtc_rst_n;
  wire [7:0] pin_s;
  wire rtc_tick_s;
  wire intruder_s;

  sync2 #(.WIDTH(1)) u_rst_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  sync2 #(.WIDTH(1)) u_rtc_rst_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RTC_WELL_RESET_N),
    .i_d(1'b1),
    .o_q(rtc_rst_n)
  );

  sync2 #(.WIDTH(8)) u_pin_sync (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_d({i_NMI_EVENT, i_SECOND_TIMEOUT_EVENT, i_BOOT_EVENT, i_SMLINK_SLAVE_EVENT,
          i_WATCHDOG_ZERO, i_NMI_STATUS_CLEAR, i_FIRMWARE_WRITE_PERMIT, i_FIRMWARE_LOCK_DOWN}),
    .o_q(pin_s)
  );

  sync2 #(.WIDTH(2)) u_rtc_sync (
    .i_clk(I_MCLK),
    .i_rst_n(rtc_rst_n),
    .i_d({i_RTC_TICK, i_INTRUDER_EVENT}),
    .o_q({rtc_tick_s, intruder_s})
  );

  wire nmi_s = pin_s[7];
  wire second_to_s = pin_s[6];
  wire boot_s = pin_s[5];
  wire smlink_s = pin_s[4];
  wire wd_zero_s = pin_s[3];
  wire nmi_clr_s = pin_s[2];
  wire permit_s = pin_s[1];
  wire lock_s = pin_s[0];

  // ==================================================
  // Edge detection on synchronised levels
  reg permit_d_r;
  reg wd_zero_d_r;
  reg nmi_d_r;
  reg second_to_d_r;
  reg boot_d_r;
  reg smlink_d_r;
  reg rtc_tick_d_r;
  reg intruder_d_r;

  always @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      permit_d_r <= 1'b0;
      wd_zero_d_r <= 1'b0;
      nmi_d_r <= 1'b0;
      second_to_d_r <= 1'b0;
      boot_d_r <= 1'b0;
      smlink_d_r <= 1'b0;
    end else if (I_CE) begin
      permit_d_r <= permit_s;
      wd_zero_d_r <= wd_zero_s;
      nmi_d_r <= nmi_s;
      second_to_d_r <= second_to_s;
      boot_d_r <= boot_s;
      smlink_d_r <= smlink_s;
    end
  end

  always @(posedge I_MCLK or negedge rtc_rst_n) begin
    if (!rtc_rst_n) begin
      rtc_tick_d_r <= 1'b0;
      intruder_d_r <= 1'b0;
    end else if (I_CE) begin
      rtc_tick_d_r <= rtc_tick_s;
      intruder_d_r <= intruder_s;
    end
  end

  wire rtc_edge = rtc_tick_s & ~rtc_tick_d_r;

  // ==================================================
  // Register write decode
  wire wr_pri = i_REG_WR & (i_REG_ADDR == `OFS_PRIMARY_LOW);
  wire wr_sec = i_REG_WR & (i_REG_ADDR == `OFS_SECONDARY);
  wire [15:0] w1_pri = wr_pri ? i_REG_WDATA : 16'h0000;
  wire [15:0] w1_sec = wr_sec ? i_REG_WDATA : 16'h0000;

  // ==================================================
  // Primary low flag set conditions
  wire fw_viol_set = (permit_s & ~permit_d_r & lock_s)
    | (i_FW_WRITE_CYCLE & permit_s & ~i_FW_WRITE_LOWER_ALIAS);
  wire century_set = i_YEAR_WR & (i_YEAR_INDEX == `YEAR_INDEX)
    & (i_YEAR_OLD == `YEAR_TOP) & (i_YEAR_NEW == `YEAR_WRAP);
  wire timeout_set = wd_zero_s & ~wd_zero_d_r;
  wire nmi_event = nmi_s & ~nmi_d_r;

  wire fw_viol;
  wire timeout;
  wire handler_message_flag;
  wire software_interrupt_flag;

  w1c_flag u_fw_viol (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_set(fw_viol_set),
    .i_clear(w1_pri[`BIT_FW_VIOL]),
    .o_flag(fw_viol)
  );

  w1c_flag u_timeout (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_set(timeout_set),
    .i_clear(w1_pri[`BIT_TIMEOUT]),
    .o_flag(timeout)
  );

  w1c_flag u_handler_msg (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_set(i_OUTBOUND_MESSAGE_WR),
    .i_clear(w1_pri[`BIT_HANDLER_MSG]),
    .o_flag(handler_message_flag)
  );

  w1c_flag u_sw_int (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_set(i_INBOUND_MESSAGE_WR),
    .i_clear(w1_pri[`BIT_SW_INT]),
    .o_flag(software_interrupt_flag)
  );

  // ==================================================
  // Rerouted NMI flag, read-only
  wire nmi_rerouted_flag;

  w1c_flag u_nmi_reroute (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_set(nmi_event & i_NMI_REROUTE_ENABLE),
    .i_clear(nmi_clr_s),
    .o_flag(nmi_rerouted_flag)
  );

  // ==================================================
  // Century flag in RTC well, clear taken at RTC tick
  reg century_r;
  reg century_clr_pend_r;

  always @(posedge I_MCLK or negedge rtc_rst_n) begin
    if (!rtc_rst_n) begin
      century_r <= 1'b0;
      century_clr_pend_r <= 1'b0;
    end else if (I_CE) begin
      if (century_set) begin
        century_r <= 1'b1;
        century_clr_pend_r <= 1'b0;
      end else if (century_clr_pend_r & rtc_edge) begin
        century_r <= 1'b0;
        century_clr_pend_r <= 1'b0;
      end else if (w1_pri[`BIT_CENTURY] & century_r) begin
        century_clr_pend_r <= 1'b1;
      end
    end
  end

  // ==================================================
  // Secondary status register
  wire [15:0] sec_set;
  wire [15:0] sec_flags;

  assign sec_set = {11'h000,
                    smlink_s & ~smlink_d_r,
                    1'b0,
                    boot_s & ~boot_d_r,
                    second_to_s & ~second_to_d_r,
                    intruder_s & ~intruder_d_r};

  genvar gi;
  generate
    for (gi = 1; gi < 16; gi = gi + 1) begin : g_sec
      if (gi == `BIT_SMLINK_SLAVE || gi == `BIT_BOOT || gi == `BIT_SECOND_TO) begin : g_live
        w1c_flag u_flag (
          .i_clk(I_MCLK),
          .i_rst_n(rst_n),
          .i_ce(I_CE),
          .i_set(sec_set[gi]),
          .i_clear(w1_sec[gi]),
          .o_flag(sec_flags[gi])
        );
      end else begin : g_rsvd
        assign sec_flags[gi] = 1'b0;
      end
    end
  endgenerate

  w1c_flag u_intruder (
    .i_clk(I_MCLK),
    .i_rst_n(rtc_rst_n),
    .i_ce(I_CE),
    .i_set(sec_set[`BIT_INTRUDER]),
    .i_clear(w1_sec[`BIT_INTRUDER]),
    .o_flag(sec_flags[`BIT_INTRUDER])
  );

  // ==================================================
  // Read mux and outputs
  reg [15:0] pri_view;
  reg [15:0] rdata_nxt;

  always @* begin
    pri_view = 16'h0000;
    pri_view[`BIT_FW_VIOL] = fw_viol;
    pri_view[`BIT_CENTURY] = century_r;
    pri_view[`BIT_TIMEOUT] = timeout;
    pri_view[`BIT_HANDLER_MSG] = handler_message_flag;
    pri_view[`BIT_SW_INT] = software_interrupt_flag;
    pri_view[`BIT_NMI_REROUTE] = nmi_rerouted_flag;
    rdata_nxt = 16'h0000;
    if (i_REG_RD) begin
      if (i_REG_ADDR == `OFS_PRIMARY_LOW) begin
        rdata_nxt = pri_view;
      end else if (i_REG_ADDR == `OFS_SECONDARY) begin
        rdata_nxt = sec_flags;
      end
    end
  end

  wire smi_any = fw_viol | century_r | timeout | handler_message_flag
    | software_interrupt_flag | nmi_rerouted_flag;

  always @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_REG_RDATA <= `SECONDARY_RESET;
      O_MGMT_INTERRUPT_N <= 1'b1;
      O_WAKE_EVENT <= 1'b0;
      O_NMI <= 1'b0;
    end else if (I_CE) begin
      O_REG_RDATA <= rdata_nxt;
      O_MGMT_INTERRUPT_N <= ~smi_any;
      O_WAKE_EVENT <= 1'b0;
      O_NMI <= nmi_event & ~i_NMI_REROUTE_ENABLE;
    end
  end

endmodule

// [logic/smi_flags_defines.vh]
`ifndef SMI_FLAGS_DEFINES_VH
`define SMI_FLAGS_DEFINES_VH

// ==================================================
// Register offsets (byte offsets from watchdog_io_base)
`define OFS_PRIMARY_LOW 8'h04
`define OFS_SECONDARY 8'h06
`define OFS_WIDTH 8

// ==================================================
// Primary status, low half
`define BIT_FW_VIOL 8
`define BIT_CENTURY 7
`define BIT_TIMEOUT 3
`define BIT_HANDLER_MSG 2
`define BIT_SW_INT 1
`define BIT_NMI_REROUTE 0

// ==================================================
// Secondary status
`define BIT_SMLINK_SLAVE 4
`define BIT_BOOT 2
`define BIT_SECOND_TO 1
`define BIT_INTRUDER 0
`define SECONDARY_RESET 16'h0000

// ==================================================
// Calendar
`define YEAR_INDEX 8'h09
`define YEAR_TOP 8'h99
`define YEAR_WRAP 8'h00

// Poll limit for a century-flag clear, in RTC clocks; the clear lands on the first RTC tick
`define CENTURY_CLEAR_RTC_CLKS 3

`endif

// [logic/sync2.v]
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Data
  input wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule

// [logic/w1c_flag.v]
module w1c_flag (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // Control
  input wire i_set,
  input wire i_clear,
  output reg o_flag
);

  // ==================================================
  // Sticky flag, set wins over clear
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_set) begin
        o_flag <= 1'b1;
      end else if (i_clear) begin
        o_flag <= 1'b0;
      end
    end
  end

endmodule

// [tb/smi_flags_props.sv]
module smi_flags_props (
  // Clock and resets
  input wire I_MCLK,
  input wire I_RESET_N,
  input wire I_CE,
  input wire I_RTC_WELL_RESET_N,
  // Sources
  input wire i_REG_WR,
  input wire [15:0] i_REG_WDATA,
  input wire i_YEAR_WR,
  input wire [7:0] i_YEAR_INDEX,
  input wire [7:0] i_YEAR_OLD,
  input wire [7:0] i_YEAR_NEW,
  input wire i_WATCHDOG_ZERO,
  input wire i_OUTBOUND_MESSAGE_WR,
  input wire i_INBOUND_MESSAGE_WR,
  input wire i_NMI_REROUTE_ENABLE,
  input wire i_NMI_STATUS_CLEAR,
  // Outputs
  input wire O_MGMT_INTERRUPT_N,
  input wire O_WAKE_EVENT,
  input wire O_NMI
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);

  // ==========
  // Properties
  property p_no_wake;
    !O_WAKE_EVENT;
  endproperty
  property p_inbound;
    I_CE && i_INBOUND_MESSAGE_WR |-> ##2 !O_MGMT_INTERRUPT_N;
  endproperty
  property p_outbound;
    I_CE && i_OUTBOUND_MESSAGE_WR |-> ##2 !O_MGMT_INTERRUPT_N;
  endproperty
  sequence s_wrap;
    I_CE && i_YEAR_WR && i_YEAR_INDEX == 8'h09 && i_YEAR_OLD == 8'h99 && i_YEAR_NEW == 8'h00;
  endsequence
  property p_century;
    s_wrap ##0 I_RTC_WELL_RESET_N |-> ##2 !O_MGMT_INTERRUPT_N;
  endproperty
  property p_timeout;
    $rose(i_WATCHDOG_ZERO) |-> ##[2:5] !O_MGMT_INTERRUPT_N;
  endproperty
  property p_no_nmi;
    i_NMI_REROUTE_ENABLE [*6] |-> !O_NMI;
  endproperty
  property p_nmi_pulse;
    O_NMI |=> !O_NMI;
  endproperty
  property p_zero_wr;
    I_CE && i_REG_WR && i_REG_WDATA == 16'h0000 && !O_MGMT_INTERRUPT_N &&
      !i_NMI_STATUS_CLEAR && I_RTC_WELL_RESET_N |-> ##2 !O_MGMT_INTERRUPT_N;
  endproperty

  // ==========
  // Checks
  a_no_wake: assert property (p_no_wake) else $error("wake raised");
  a_inbound: assert property (p_inbound) else $error("inbound no irq");
  a_outbound: assert property (p_outbound) else $error("outbound no irq");
  a_century: assert property (p_century) else $error("wrap no irq");
  a_timeout: assert property (p_timeout) else $error("timeout no irq");
  a_no_nmi: assert property (p_no_nmi) else $error("nmi while rerouted");
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi too long");
  a_zero_wr: assert property (p_zero_wr) else $error("zero write cleared");
  c_inbound: cover property (i_INBOUND_MESSAGE_WR);
  c_century: cover property (s_wrap);
  c_nmi: cover property (O_NMI);
endmodule

bind smi_source_status_flags smi_flags_props u_props (.*);

// [tb/smi_source_status_flags_test.sv]
`include "smi_flags_defines.vh"

module smi_source_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] P = `OFS_PRIMARY_LOW;
  localparam [7:0] S = `OFS_SECONDARY;
  logic I_MCLK = 0, I_RESET_N = 0, I_CE = 1, I_RTC_WELL_RESET_N = 0;
  logic i_REG_WR = 0, i_REG_RD = 0, i_FIRMWARE_WRITE_PERMIT = 0;
  logic i_FIRMWARE_LOCK_DOWN = 0, i_FW_WRITE_CYCLE = 0, i_FW_WRITE_LOWER_ALIAS = 0;
  logic i_RTC_TICK = 0, i_YEAR_WR = 0, i_WATCHDOG_ZERO = 0, i_NMI_EVENT = 0;
  logic i_OUTBOUND_MESSAGE_WR = 0, i_INBOUND_MESSAGE_WR = 0, i_NMI_STATUS_CLEAR = 0;
  logic i_NMI_REROUTE_ENABLE = 0, i_INTRUDER_EVENT = 0, i_SECOND_TIMEOUT_EVENT = 0;
  logic i_BOOT_EVENT = 0, i_SMLINK_SLAVE_EVENT = 0, seen = 0;
  logic [7:0] i_REG_ADDR = 0, i_YEAR_INDEX = 0, i_YEAR_OLD = 0, i_YEAR_NEW = 0;
  logic [15:0] i_REG_WDATA = 0;
  logic [15:0] got;
  wire [15:0] O_REG_RDATA;
  wire O_MGMT_INTERRUPT_N, O_WAKE_EVENT, O_NMI;
  int fail_count = 0, checks_done = 0, k;

  smi_source_status_flags uut (.*);

  initial forever #2.5 I_MCLK = ~I_MCLK;

  // ==========
  // Tasks
  task cyc(input int n);
    repeat (n) @(negedge I_MCLK);
  endtask
  task chk(input string n, input [15:0] s, input [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(negedge I_MCLK);
    i_REG_WR = 1;
    i_REG_ADDR = a;
    i_REG_WDATA = d;
    @(negedge I_MCLK);
    i_REG_WR = 0;
  endtask
  // Read strobe for one edge, data taken just after it drops
  task peek(input [7:0] a, output [15:0] v);
    @(negedge I_MCLK);
    i_REG_RD = 1;
    i_REG_ADDR = a;
    @(negedge I_MCLK);
    i_REG_RD = 0;
    v = O_REG_RDATA;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    logic [15:0] v;
    peek(a, v);
    chk("rdata", v, e);
  endtask
  task set(input int n, input logic v);
    case (n)
      0: i_INBOUND_MESSAGE_WR = v;
      1: i_OUTBOUND_MESSAGE_WR = v;
      2: i_FW_WRITE_CYCLE = v;
      3: i_YEAR_WR = v;
      4: i_WATCHDOG_ZERO = v;
      5: i_NMI_EVENT = v;
      6: i_INTRUDER_EVENT = v;
      7: i_SECOND_TIMEOUT_EVENT = v;
      8: i_BOOT_EVENT = v;
      9: i_SMLINK_SLAVE_EVENT = v;
      default: i_RTC_TICK = v;
    endcase
  endtask
  // One-cycle pulse, then room for the synchronisers
  task pulse(input int n);
    @(negedge I_MCLK);
    set(n, 1);
    @(negedge I_MCLK);
    set(n, 0);
    cyc(6);
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // Sequence
  initial begin
    cyc(8);
    I_RESET_N = 1;
    I_RTC_WELL_RESET_N = 1;
    cyc(3);
    chk("int_n", O_MGMT_INTERRUPT_N, 1);
    rd(P, 16'h0000);
    rd(S, `SECONDARY_RESET);
    rd(8'h10, 16'h0000);
    $display("reset test done");
    pulse(0);
    pulse(1);
    rd(P, 16'h0006);
    chk("int_n", O_MGMT_INTERRUPT_N, 0);
    wr(P, 16'h0000);
    wr(8'h10, 16'hffff);
    rd(P, 16'h0006);
    wr(P, 16'h0002);
    rd(P, 16'h0004);
    wr(P, 16'h0004);
    rd(P, 16'h0000);
    chk("int_n", O_MGMT_INTERRUPT_N, 1);
    pulse(4);
    rd(P, 16'h0008);
    wr(P, 16'h0008);
    rd(P, 16'h0000);
    // Enable low: a message write must leave no trace
    I_CE = 0;
    pulse(0);
    I_CE = 1;
    rd(P, 16'h0000);
    $display("message and timeout test done");
    // Permit rising without lock-down is legal
    i_FIRMWARE_WRITE_PERMIT = 1;
    cyc(6);
    rd(P, 16'h0000);
    i_FIRMWARE_WRITE_PERMIT = 0;
    i_FIRMWARE_LOCK_DOWN = 1;
    cyc(6);
    i_FIRMWARE_WRITE_PERMIT = 1;
    cyc(6);
    rd(P, 16'h0100);
    wr(P, 16'h0100);
    i_FW_WRITE_LOWER_ALIAS = 1;
    pulse(2);
    rd(P, 16'h0000);
    i_FW_WRITE_LOWER_ALIAS = 0;
    pulse(2);
    rd(P, 16'h0100);
    wr(P, 16'h0100);
    rd(P, 16'h0000);
    $display("firmware test done");
    i_YEAR_INDEX = `YEAR_INDEX;
    i_YEAR_OLD = 8'h98;
    i_YEAR_NEW = 8'h99;
    pulse(3);
    rd(P, 16'h0000);
    i_YEAR_OLD = `YEAR_TOP;
    i_YEAR_NEW = `YEAR_WRAP;
    pulse(3);
    rd(P, 16'h0080);
    chk("int_n", O_MGMT_INTERRUPT_N, 0);
    chk("wake", O_WAKE_EVENT, 0);
    wr(P, 16'h0080);
    // Handler polls, one RTC clock at a time, until the flag reads clear
    got = 16'h0080;
    for (k = 0; k < `CENTURY_CLEAR_RTC_CLKS && got[`BIT_CENTURY]; k++) begin
      pulse(10);
      peek(P, got);
    end
    chk("century", got, 16'h0000);
    pulse(3);
    rd(P, 16'h0080);
    I_RTC_WELL_RESET_N = 0;
    cyc(2);
    I_RTC_WELL_RESET_N = 1;
    cyc(3);
    rd(P, 16'h0000);
    // After RTC power loss: legal time first, then clear
    i_YEAR_OLD = 8'h98;
    i_YEAR_NEW = 8'h99;
    pulse(3);
    wr(P, 16'h0080);
    rd(P, 16'h0000);
    $display("century test done");
    i_NMI_EVENT = 1;
    for (k = 0; k < 12; k++) begin
      cyc(1);
      if (O_NMI === 1'b1) seen = 1;
    end
    i_NMI_EVENT = 0;
    chk("nmi", seen, 1);
    rd(P, 16'h0000);
    i_NMI_REROUTE_ENABLE = 1;
    cyc(6);
    pulse(5);
    rd(P, 16'h0001);
    wr(P, 16'h0001);
    rd(P, 16'h0001);
    i_NMI_STATUS_CLEAR = 1;
    cyc(6);
    i_NMI_STATUS_CLEAR = 0;
    cyc(3);
    rd(P, 16'h0000);
    $display("nmi test done");
    for (k = 6; k < 10; k++) pulse(k);
    rd(S, 16'h0017);
    wr(S, 16'h0017);
    rd(S, 16'h0000);
    $display("secondary test done");
    give_verdict;
  end
endmodule
